/* File: logic/psx_seq_exec.sv */
// per-port sequence call, abort, restart and status logic
//
// Operation
// R1: accepted call sets busy; failed call leaves clear
// R2: busy clears on completion or abort
// R3: refuse new call while one runs
// R4: host calls only while busy is clear
// R5: step error sets step-error flag
// R6: only successful retry clears step-error flag; the code also clears it when a new call is accepted
// R7: step-error stays set across later good steps
// R8: normal end sets end flag
// R9: abort processing sets abort flag
// R10: abort request aborts running sequence
// R11: restart initialises buffers and status words
// R12: restart waits until running sequence finishes
// R13: restart bit clears itself when done
// R14: record reception case number per port
// R15: record last executed step number per port
// R16: stored flag set on case/step write
// R17: host sends zero when no send data
// R18: no receive data leaves destination untouched
// R19: call word: port top digit, BCD sequence
// R20: refused call raises error indication
// R21: host holds abort at least 15 ms
// R22: reset clears all flags, bits, fields
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module psx_seq_exec (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    // register port
    input  wire logic [7:0]               regAddr,
    input  wire logic [15:0]              regWdata,
    input  wire logic                     regWr,
    input  wire logic                     regRd,
    output logic      [15:0]              regRdata,
    // sequence engine side
    output psx_pkg::psx_call_t            engCall,
    output logic      [1:0]               engAbort,
    output logic      [1:0]               engInit,
    output logic      [1:0]               rxStoreEn,
    input  wire psx_pkg::psx_ev_t [1:0]   engEv
);

    // ========================================================
    // helpers

    // a digit is valid decimal when not above nine
    function automatic logic isBcd(input logic [3:0] d);
        isBcd = (d <= psx_pkg::BCD_MAX);
    endfunction

    // status word layout for one port
    function automatic logic [15:0] statWord(
        input logic       busy,
        input logic       sErr,
        input logic       endF,
        input logic       abtF,
        input logic       stored,
        input logic [3:0] caseNo,
        input logic [3:0] stepNo
    );
        statWord = psx_pkg::WORD_RST;
        statWord[psx_pkg::ST_BUSY]               = busy;
        statWord[psx_pkg::ST_STEP_ERR]           = sErr;
        statWord[psx_pkg::ST_END]                = endF;
        statWord[psx_pkg::ST_ABORT]              = abtF;
        statWord[psx_pkg::ST_STORED]             = stored;
        statWord[psx_pkg::ST_CASE_LSB +: 4]      = caseNo;
        statWord[psx_pkg::ST_STEP_LSB +: 4]      = stepNo;
    endfunction

    // ========================================================
    // bus decode
    wire logic wrCall = regWr && (regAddr == psx_pkg::ADDR_CALL);
    wire logic wrCtrl = regWr && (regAddr == psx_pkg::ADDR_CTRL);
    wire logic wrErr  = regWr && (regAddr == psx_pkg::ADDR_ERR);

    // ========================================================
    // call word decode
    wire logic [3:0] cmdPort = regWdata[psx_pkg::CMD_PORT_LSB +: 4];
    wire logic       seqBcd  = isBcd(regWdata[3:0]) && isBcd(regWdata[7:4])
                               && isBcd(regWdata[11:8]); // R19
    wire logic       portOk  = (cmdPort == psx_pkg::PORT_A_CODE)
                               || (cmdPort == psx_pkg::PORT_B_CODE); // R19
    wire logic       portSel = (cmdPort == psx_pkg::PORT_B_CODE);

    // per-port state seen by the shared call gate
    psx_pkg::psx_state_t state [1:0];
    logic [1:0]          abortBit;
    logic [1:0]          restartBit;

    // only one call at a time across both ports; abort and restart
    // windows also block, since the engine is still tidying up
    wire logic anyBusy  = (state[0] != psx_pkg::ST_IDLE)
                          || (state[1] != psx_pkg::ST_IDLE)
                          || (abortBit != 2'b00)
                          || (restartBit != 2'b00);
    wire logic callOk   = wrCall && portOk && seqBcd && !anyBusy; // R3
    wire logic callFail = wrCall && !callOk; // R20

    // ========================================================
    // abort bits: owned by software, held for the engine
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            abortBit <= 2'b00; // R22
        end else if (wrCtrl) begin
            abortBit <= regWdata[psx_pkg::CTRL_ABORT_LSB +: 2];
        end
    end

    // ========================================================
    // call error indication, sticky, write one to clear
    logic callErr;
    wire logic next_callErr = callFail
                              || (callErr && !(wrErr && regWdata[psx_pkg::ERR_CALL]));

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            callErr <= 1'b0; // R22
        end else begin
            callErr <= next_callErr; // R20
        end
    end

    // ========================================================
    // start strobe to the engine, one cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            engCall <= '0;
        end else begin
            engCall.start <= callOk; // R1
            engCall.port  <= portSel;
            engCall.seq   <= regWdata[11:0];
        end
    end

    // ========================================================
    // per-port flags and sequencing
    logic [15:0] stat [1:0];

    for (genvar p = 0; p < 2; p++) begin : gPort
        logic       sErr;
        logic       endF;
        logic       abtF;
        logic       stored;
        logic [3:0] caseNo;
        logic [3:0] stepNo;

        wire logic running = (state[p] == psx_pkg::ST_RUN);
        wire logic initing = (state[p] == psx_pkg::ST_INIT);
        wire logic startP  = callOk && (portSel == 1'(p));
        wire logic evDone  = running && engEv[p].done;
        wire logic evAbt   = engEv[p].aborted && (running || abortBit[p]);
        // the host abort drops busy at once; the engine still
        // finishes its own abort processing behind it
        wire logic finish  = running && (evDone || evAbt || abortBit[p]); // R2 R10
        wire logic rstWr   = wrCtrl && regWdata[psx_pkg::CTRL_RESTART_LSB + p];
        wire logic caseWr  = running && engEv[p].caseValid; // R14
        wire logic stepWr  = running && engEv[p].stepValid; // R15

        // next state: restart is held off while a sequence runs
        psx_pkg::psx_state_t next_state;
        assign next_state = startP                       ? psx_pkg::ST_RUN  // R1
                          : finish                       ? psx_pkg::ST_IDLE // R2
                          : (!running && !initing && restartBit[p])
                                                         ? psx_pkg::ST_INIT // R12
                          : initing                      ? psx_pkg::ST_IDLE
                          : state[p];

        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                state[p] <= psx_pkg::ST_IDLE; // R22
            end else begin
                state[p] <= next_state;
            end
        end

        // restart bit: software sets, hardware clears after init;
        // a fresh write in the init cycle wins over the clear
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                restartBit[p] <= 1'b0; // R22
            end else if (rstWr) begin
                restartBit[p] <= 1'b1; // R11
            end else if (initing) begin
                restartBit[p] <= 1'b0; // R13
            end
        end

        // step error: set wins over retry clear, no other clear
        // while running, so later good steps leave it set
        always_ff @(posedge clk_sys) begin
            if (!nrst || initing || startP) begin
                sErr <= 1'b0; // R22 R11
            end else if (running && engEv[p].stepErr) begin
                sErr <= 1'b1; // R5 R7
            end else if (running && engEv[p].retryOk) begin
                sErr <= 1'b0; // R6
            end
        end

        // end and abort flags are fresh for each call
        always_ff @(posedge clk_sys) begin
            if (!nrst || initing || startP) begin
                endF <= 1'b0; // R22 R11
                abtF <= 1'b0;
            end else begin
                if (evDone) begin
                    endF <= 1'b1; // R8
                end
                if (evAbt) begin
                    abtF <= 1'b1; // R9
                end
            end
        end

        // recorded case and step numbers with stored indication
        always_ff @(posedge clk_sys) begin
            if (!nrst || initing) begin
                caseNo <= psx_pkg::NIB_RST; // R22 R11
                stepNo <= psx_pkg::NIB_RST;
                stored <= 1'b0;
            end else begin
                if (caseWr) begin
                    caseNo <= engEv[p].caseNo; // R14
                end
                if (stepWr) begin
                    stepNo <= engEv[p].stepNo; // R15
                end
                if (caseWr || stepWr) begin
                    stored <= 1'b1; // R16
                end
            end
        end

        // engine controls; receive words pass only for a live
        // sequence that delivers data, else the target is left alone
        assign engAbort[p]  = abortBit[p]; // R10
        assign engInit[p]   = initing; // R11
        assign rxStoreEn[p] = running && engEv[p].rxValid; // R18

        assign stat[p] = statWord(running, sErr, endF, abtF,
                                  stored, caseNo, stepNo);
    end

    // ========================================================
    // read mux, answered in the next cycle; unmapped reads zero
    logic [15:0] ctrlWord;
    always_comb begin
        ctrlWord = psx_pkg::WORD_RST;
        ctrlWord[psx_pkg::CTRL_ABORT_LSB +: 2]   = abortBit;
        ctrlWord[psx_pkg::CTRL_RESTART_LSB +: 2] = restartBit;
    end

    logic [15:0] rdMux;
    always_comb begin
        case (regAddr)
            psx_pkg::ADDR_CTRL:   rdMux = ctrlWord;
            psx_pkg::ADDR_STAT_A: rdMux = stat[0];
            psx_pkg::ADDR_STAT_B: rdMux = stat[1];
            psx_pkg::ADDR_ERR:    rdMux = {15'h0000, callErr};
            default:              rdMux = psx_pkg::WORD_RST;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            regRdata <= psx_pkg::WORD_RST;
        end else begin
            regRdata <= regRd ? rdMux : psx_pkg::WORD_RST;
        end
    end

endmodule

`default_nettype wire

/* File: inc/psx_pkg.sv */
// constants and types shared by the sequence execution status block
package psx_pkg;

    // ========================================================
    // register map (byte addresses, one 16-bit word each)
    localparam logic [7:0] ADDR_CALL   = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_STAT_A = 8'h08;
    localparam logic [7:0] ADDR_STAT_B = 8'h0C;
    localparam logic [7:0] ADDR_ERR    = 8'h10;

    // ========================================================
    // field positions
    localparam int CTRL_ABORT_LSB   = 0;   // bit0 port A, bit1 port B
    localparam int CTRL_RESTART_LSB = 2;   // bit2 port A, bit3 port B
    localparam int ST_BUSY          = 0;
    localparam int ST_STEP_ERR      = 1;
    localparam int ST_END           = 2;
    localparam int ST_ABORT         = 3;
    localparam int ST_STORED        = 4;
    localparam int ST_CASE_LSB      = 8;
    localparam int ST_STEP_LSB      = 12;
    localparam int ERR_CALL         = 0;
    localparam int CMD_PORT_LSB     = 12;

    // ========================================================
    // codes and reset values
    localparam logic [3:0]  PORT_A_CODE = 4'h1;
    localparam logic [3:0]  PORT_B_CODE = 4'h2;
    localparam logic [3:0]  BCD_MAX     = 4'h9;
    localparam logic [15:0] WORD_RST    = 16'h0000;
    localparam logic [3:0]  NIB_RST     = 4'h0;

    // ========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_INIT = 3'b100
    } psx_state_t;

    // events reported by the sequence engine for one port
    typedef struct packed {
        logic       stepErr;
        logic       retryOk;
        logic       stepValid;
        logic [3:0] stepNo;
        logic       caseValid;
        logic [3:0] caseNo;
        logic       done;
        logic       aborted;
        logic       rxValid;
    } psx_ev_t;

    // sequence start handed to the engine
    typedef struct packed {
        logic        start;
        logic        port;
        logic [11:0] seq;
    } psx_call_t;

endpackage

/* File: testbench/psx_seq_exec_props.sv */
// checker on the ports of the sequence execution status block
`timescale 1ns/1ns
`default_nettype none
module psx_seq_exec_props (
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    // register port
    input wire logic [7:0]             regAddr,
    input wire logic [15:0]            regWdata,
    input wire logic                   regWr,
    input wire logic                   regRd,
    input wire logic [15:0]            regRdata,
    // engine side
    input wire psx_pkg::psx_call_t     engCall,
    input wire logic [1:0]             engAbort,
    input wire logic [1:0]             engInit,
    input wire logic [1:0]             rxStoreEn,
    input wire psx_pkg::psx_ev_t [1:0] engEv
);
    // ==========
    // host write decodes
    wire logic       callWr = regWr && regAddr == psx_pkg::ADDR_CALL;
    wire logic [3:0] dig = regWdata[15:12];
    wire logic       badPort = callWr && dig != psx_pkg::PORT_A_CODE && dig != psx_pkg::PORT_B_CODE;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========
    // assertions
    a_rdata_cause: assert property (regRdata != 16'h0000 |-> $past(regRd))
        else $error("read data without read");
    a_start_cause: assert property (engCall.start |-> $past(callWr))
        else $error("start without call write");
    a_start_port: assert property (engCall.start |->
        engCall.port == ($past(dig) == psx_pkg::PORT_B_CODE)) else $error("wrong port");
    a_start_seq: assert property (engCall.start |-> engCall.seq == $past(regWdata[11:0]))
        else $error("wrong sequence number");
    a_bad_port: assert property (badPort |=> !engCall.start)
        else $error("bad port accepted");
    a_double_call: assert property (engCall.start ##1 callWr |=> !engCall.start)
        else $error("second call accepted");
    a_abort_copy: assert property (regWr && regAddr == psx_pkg::ADDR_CTRL |=>
        engAbort == $past(regWdata[1:0])) else $error("abort bits not taken");
    a_rx_gate: assert property (rxStoreEn[0] |-> engEv[0].rxValid)
        else $error("store without receive");
    a_init_pulse: assert property (engInit[0] |=> !engInit[0])
        else $error("init longer than one cycle");
    a_reset_clear: assert property (disable iff (1'b0) !nrst |=> engAbort == 2'b00
        && engInit == 2'b00 && !engCall.start) else $error("output set after reset");
    // main scenarios reached
    c_start: cover property (engCall.start);
    c_init: cover property (engInit[0]);
    c_abort: cover property (engEv[1].aborted);
endmodule
bind psx_seq_exec psx_seq_exec_props u_psx_seq_exec_props (.clk_sys(clk_sys), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .engCall(engCall), .engAbort(engAbort), .engInit(engInit), .rxStoreEn(rxStoreEn),
    .engEv(engEv));
`default_nettype wire

/* File: testbench/psx_engine_model.sv */
// sequence engine model that answers calls with step, case and end events
`timescale 1ns/1ns
`default_nettype none
module psx_engine_model (
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                nrst,
    // from the block
    input wire psx_pkg::psx_call_t  engCall,
    input wire logic [1:0]          engAbort,
    // bit0 step error, bit1 retry ok, bit2 hang, bit3 slow
    input wire logic [3:0]          mode,
    // events to the block
    output psx_pkg::psx_ev_t [1:0]  engEv
);
    logic             run;
    logic             prt;
    logic             abt;
    logic [4:0]       cnt;
    logic [11:0]      seq;
    psx_pkg::psx_ev_t ev;
    // ==========
    // one sequence at a time, the block refuses overlap
    always_ff @(posedge clk_sys) begin
        abt <= nrst && run && engAbort[prt];
        if (!nrst) begin
            run <= 1'b0;
            prt <= 1'b0;
            seq <= 12'h000;
            cnt <= 5'h00;
        end else if ((run && engAbort[prt]) || ev.done) begin
            run <= 1'b0;
        end else if (engCall.start) begin
            run <= 1'b1;
            prt <= engCall.port;
            seq <= engCall.seq;
            cnt <= 5'h00;
        end else begin
            cnt <= cnt + 5'h01;
        end
    end
    // event script; hang mode never ends so only an abort frees it
    always_comb begin
        ev = '0;
        ev.stepValid = run && (cnt == 5'h02 || cnt == 5'h04);
        ev.stepErr = run && cnt == 5'h02 && mode[0];
        ev.stepNo = seq[3:0] + {3'h0, cnt == 5'h04};
        ev.retryOk = run && cnt == 5'h05 && mode[1];
        ev.caseValid = run && cnt == 5'h06;
        ev.caseNo = seq[7:4];
        ev.rxValid = ev.caseValid;
        ev.done = run && !mode[2] && cnt == (mode[3] ? 5'h14 : 5'h09);
        ev.aborted = abt;
    end
    assign engEv[0] = prt ? '0 : ev;
    assign engEv[1] = prt ? ev : '0;
endmodule
`default_nettype wire

/* File: testbench/tb_psx_seq_exec.sv */
// self-checking bench for the sequence execution status block
`timescale 1ns/1ns
`default_nettype none
module tb_psx_seq_exec;
    logic                   clk_sys = 1'b0;
    logic                   nrst = 1'b0;
    logic [7:0]             regAddr = 8'h00;
    logic [15:0]            regWdata = 16'h0000;
    logic                   regWr = 1'b0;
    logic                   regRd = 1'b0;
    logic [15:0]            regRdata;
    psx_pkg::psx_call_t     engCall;
    logic [1:0]             engAbort;
    logic [1:0]             engInit;
    logic [1:0]             rxStoreEn;
    psx_pkg::psx_ev_t [1:0] engEv;
    logic [3:0]             mode = 4'h0;
    logic [15:0]            initCnt = 16'h0000;
    logic [15:0]            rxCnt = 16'h0000;
    logic [15:0]            d;
    logic                   st;
    logic                   p;
    logic [11:0]            s;
    logic [3:0]             m;
    logic [7:0]             a;
    int                     badCount = 0;
    int                     nTests = 0;
    int                     cycles = 0;
    always #5 clk_sys = ~clk_sys;
    psx_seq_exec u_psx_seq_exec (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .engCall(engCall), .engAbort(engAbort), .engInit(engInit), .rxStoreEn(rxStoreEn),
        .engEv(engEv));
    psx_engine_model u_psx_engine_model (.clk_sys(clk_sys), .nrst(nrst), .engCall(engCall),
        .engAbort(engAbort), .mode(mode), .engEv(engEv));
    // ==========
    // bus tasks; every strobe lasts one cycle then one idle cycle
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        nTests++;
        if (g !== e) begin
            badCount++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [15:0] w);
        regWr <= 1'b1;
        regAddr <= ad;
        regWdata <= w;
        @(posedge clk_sys);
        regWr <= 1'b0;
        #1 st = engCall.start;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] ad);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdata;
        @(posedge clk_sys);
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [15:0] e);
        rd(ad);
        chk(d, e);
    endtask
    // polls status, bounded so a stuck busy flag shows up as a mismatch
    task automatic waitIdle(input logic [7:0] ad);
        int k;
        k = 0;
        do begin
            rd(ad);
            k++;
        end while (d[psx_pkg::ST_BUSY] !== 1'b0 && k < 40);
    endtask
    function automatic logic [15:0] stw(logic se, logic [3:0] c, logic [3:0] n);
        return {n, c, 3'h0, 1'b1, 1'b0, 1'b1, se, 1'b0};
    endfunction
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========
    // cycle limit and init pulse counter
    always @(posedge clk_sys) begin
        cycles++;
        if (engInit[0] === 1'b1) initCnt <= initCnt + 16'h0001;
        // one receive word per live run; a stuck-low gate would pass the assertion alone
        if ((|rxStoreEn) === 1'b1) rxCnt <= rxCnt + 16'h0001;
        if (cycles == 5000) begin
            badCount++;
            tallyAndFinish();
        end
    end
    initial begin
        void'($urandom(96));
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rdc(psx_pkg::ADDR_STAT_A, 16'h0000);
        rdc(psx_pkg::ADDR_STAT_B, 16'h0000);
        rdc(8'h14, 16'h0000);
        wr(psx_pkg::ADDR_CALL, 16'h3123);
        chk({15'h0, st}, 16'h0000);
        wr(psx_pkg::ADDR_CALL, 16'h1A05);
        chk({15'h0, st}, 16'h0000);
        rdc(psx_pkg::ADDR_ERR, 16'h0001);
        wr(psx_pkg::ADDR_ERR, 16'h0001);
        rdc(psx_pkg::ADDR_STAT_A, 16'h0000);
        // random calls; first four modes fixed so error and retry both occur
        for (int i = 0; i < 8; i++) begin
            p = 1'($urandom % 2);
            s = {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 9)};
            m = (i < 4) ? 4'(i) : 4'($urandom % 4);
            m[3] = (i % 3 == 2);
            mode <= m;
            a = p ? psx_pkg::ADDR_STAT_B : psx_pkg::ADDR_STAT_A;
            wr(psx_pkg::ADDR_CALL, {p ? psx_pkg::PORT_B_CODE : psx_pkg::PORT_A_CODE, s});
            chk({15'h0, st}, 16'h0001);
            if (i == 0) begin
                wr(psx_pkg::ADDR_CALL, 16'h1001);
                chk({15'h0, st}, 16'h0000);
                rdc(psx_pkg::ADDR_ERR, 16'h0001);
                wr(psx_pkg::ADDR_ERR, 16'h0001);
            end
            rd(a);
            chk({15'h0, d[0]}, 16'h0001);
            waitIdle(a);
            chk(d, stw(m[0] && !m[1], s[7:4], s[3:0] + 4'h1));
        end
        chk(rxCnt, 16'h0008);
        // hung sequence on port B is aborted; bit held several cycles
        mode <= 4'h4;
        wr(psx_pkg::ADDR_CALL, 16'h2350);
        wr(psx_pkg::ADDR_CTRL, 16'h0002);
        repeat (4) @(posedge clk_sys);
        rd(psx_pkg::ADDR_STAT_B);
        chk(d & 16'h000F, 16'h0008);
        wr(psx_pkg::ADDR_CTRL, 16'h0000);
        // restart during a run waits for the end, then clears itself
        mode <= 4'h0;
        wr(psx_pkg::ADDR_CALL, 16'h1042);
        wr(psx_pkg::ADDR_CTRL, 16'h0004);
        chk(initCnt, 16'h0000);
        rd(psx_pkg::ADDR_STAT_A);
        chk({15'h0, d[0]}, 16'h0001);
        waitIdle(psx_pkg::ADDR_STAT_A);
        repeat (3) @(posedge clk_sys);
        chk(initCnt, 16'h0001);
        rdc(psx_pkg::ADDR_STAT_A, 16'h0000);
        rdc(psx_pkg::ADDR_CTRL, 16'h0000);
        wr(psx_pkg::ADDR_CALL, 16'h1042);
        chk({15'h0, st}, 16'h0001);
        waitIdle(psx_pkg::ADDR_STAT_A);
        rdc(psx_pkg::ADDR_ERR, 16'h0000);
        tallyAndFinish();
    end
endmodule
`default_nettype wire
